// file: logic/cies_alu.v
// combinational result and flag logic for the execute subset
// assumes operands are stable from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cies_consts.vh"
module cies_alu (
   input  wire [3:0] op,
   input  wire [7:0] file_data,
   input  wire [7:0] w_data,
   input  wire [7:0] literal,
   input  wire [2:0] bit_sel,
   input  wire       carry_in,
   output reg  [7:0] result,
   output reg        carry_out,
   output reg        z_update,
   output reg        c_update
);
   //////////////////////////////////////////////////////////////////////////////
   always @* begin
      result    = file_data;
      carry_out = carry_in;
      z_update  = 1'b0;
      c_update  = 1'b0;
      case (op)
         `CIES_OP_BIT_SET: begin
            result = file_data | (8'h01 << bit_sel);
         end
         `CIES_OP_SHIFT_LEFT: begin
            result    = {file_data[6:0], 1'b0};
            carry_out = file_data[7];
            z_update  = 1'b1;
            c_update  = 1'b1;
         end
         `CIES_OP_SHIFT_RIGHT: begin
            result    = {1'b0, file_data[7:1]};
            carry_out = file_data[0];
            z_update  = 1'b1;
            c_update  = 1'b1;
         end
         `CIES_OP_MOVE: begin
            result   = file_data;
            z_update = 1'b1;
         end
         `CIES_OP_SWAP: begin
            result = {file_data[3:0], file_data[7:4]};
         end
         `CIES_OP_XOR_IMM: begin
            result   = w_data ^ literal;
            z_update = 1'b1;
         end
         `CIES_OP_XOR_REG: begin
            result   = w_data ^ file_data;
            z_update = 1'b1;
         end
         default: begin
            result = w_data;
         end
      endcase
   end
endmodule // cies_alu
`default_nettype wire

// file: logic/cies_consts.vh
// constants for the instruction execute subset block
// assumes a 14-bit instruction word, 15-bit program counter, 8-bit data
`ifndef CIES_CONSTS_VH
`define CIES_CONSTS_VH
`define CIES_OP_NONE        4'h0
`define CIES_OP_REL_JUMP    4'h1
`define CIES_OP_BIT_SET     4'h2
`define CIES_OP_SHIFT_LEFT  4'h3
`define CIES_OP_SHIFT_RIGHT 4'h4
`define CIES_OP_MOVE        4'h5
`define CIES_OP_SWAP        4'h6
`define CIES_OP_XOR_IMM     4'h7
`define CIES_OP_XOR_REG     4'h8
`define CIES_OP_DIR_LOAD    4'h9
`define CIES_DIR_PORT_A     3'h5
`define CIES_DIR_PORT_B     3'h6
`define CIES_DIR_PORT_C     3'h7
`define CIES_DIR_RESET      8'hFF
`define CIES_PC_RESET       15'h0000
`define CIES_W_RESET        8'h00
`define CIES_FLAG_RESET     1'b0
`define CIES_FADDR_RESET    7'h00
`define CIES_FDATA_RESET    8'h00
`define CIES_PC_STEP        15'h0001
`define CIES_DIR_HIGH       4'h0
`endif

// file: logic/cies_core.v
// execute stage for the instruction subset: pc, working register, flags, direction
// assumes decoded op and operands valid with exec_valid; file data read combinationally
`timescale 1ns/1ps
`default_nettype none
`include "cies_consts.vh"
module cies_core (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        exec_valid,
   input  wire [3:0]  exec_op,
   input  wire [6:0]  file_addr,
   input  wire        dest_file,
   input  wire [2:0]  bit_sel,
   input  wire [7:0]  literal,
   input  wire [7:0]  file_rdata,
   input  wire [2:0]  dc_in,
   output reg  [14:0] pc,
   output reg  [7:0]  w_reg,
   output reg         flag_c,
   output reg         flag_dc,
   output reg         flag_z,
   output reg  [7:0]  port_a_direction,
   output reg  [7:0]  port_b_direction,
   output reg  [7:0]  port_c_direction,
   output reg         file_we,
   output reg  [6:0]  file_waddr,
   output reg  [7:0]  file_wdata,
   output wire        busy
);
   //////////////////////////////////////////////////////////////////////////////
   localparam ST_RUN   = 1'b0;
   localparam ST_FLUSH = 1'b1;
   reg        state;
   wire [7:0] result;
   wire       carry_out;
   wire       z_update;
   wire       c_update;
   wire       take;
   wire       to_w;
   reg        next_state;
   cies_alu u_alu (
      .op        (exec_op),
      .file_data (file_rdata),
      .w_data    (w_reg),
      .literal   (literal),
      .bit_sel   (bit_sel),
      .carry_in  (flag_c),
      .result    (result),
      .carry_out (carry_out),
      .z_update  (z_update),
      .c_update  (c_update)
   );
   assign busy = (state == ST_FLUSH);
   assign take = exec_valid && (state == ST_RUN);
   //////////////////////////////////////////////////////////////////////////////
   // dest bit choice; xor immediate always to w
   assign to_w = (exec_op == `CIES_OP_XOR_IMM) ||
                 (!dest_file && (exec_op == `CIES_OP_SHIFT_LEFT || exec_op == `CIES_OP_SHIFT_RIGHT ||
                  exec_op == `CIES_OP_MOVE || exec_op == `CIES_OP_SWAP ||
                  exec_op == `CIES_OP_XOR_REG));
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (take && exec_op == `CIES_OP_REL_JUMP) begin
               next_state = ST_FLUSH;
            end
         end
         ST_FLUSH: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end
   //////////////////////////////////////////////////////////////////////////////
   // next values and helpers
   reg  [14:0] next_pc;
   reg  [7:0]  next_w_reg;
   reg         next_flag_c;
   reg         next_flag_dc;
   reg         next_flag_z;
   reg  [7:0]  next_port_a_direction;
   reg  [7:0]  next_port_b_direction;
   reg  [7:0]  next_port_c_direction;
   reg         next_file_we;
   reg  [6:0]  next_file_waddr;
   reg  [7:0]  next_file_wdata;
   wire [14:0] pc_step;
   wire [14:0] jump_target;
   wire        discard;
   wire        is_jump;
   wire        is_dir_load;
   wire        to_file;
   wire        result_zero;
   wire        z_write;
   wire        c_write;

   //////////////////////////////////////////////////////////////////////////////
   // instruction class decode
   assign discard     = (state == ST_FLUSH);
   assign is_jump     = take && (exec_op == `CIES_OP_REL_JUMP);
   assign is_dir_load = take && (exec_op == `CIES_OP_DIR_LOAD);
   assign to_file     = !to_w && ((exec_op == `CIES_OP_BIT_SET) ||
                        (exec_op == `CIES_OP_SHIFT_LEFT) ||
                        (exec_op == `CIES_OP_SHIFT_RIGHT) ||
                        (exec_op == `CIES_OP_MOVE) ||
                        (exec_op == `CIES_OP_SWAP) ||
                        (exec_op == `CIES_OP_XOR_REG));
   assign result_zero = (result == 8'h00);
   assign z_write     = take && z_update;
   assign c_write     = take && c_update;

   //////////////////////////////////////////////////////////////////////////////
   // program counter arithmetic
   assign pc_step     = pc + `CIES_PC_STEP;
   assign jump_target = pc_step + {7'h00, w_reg};

   //////////////////////////////////////////////////////////////////////////////
   // next program counter
   always @* begin
      next_pc = pc;
      if (discard) begin
         next_pc = pc;
      end else if (is_jump) begin
         next_pc = jump_target;
      end else if (take) begin
         next_pc = pc_step;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // next working register
   always @* begin
      next_w_reg = w_reg;
      if (take && to_w) begin
         next_w_reg = result;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // next flags
   always @* begin
      next_flag_c = flag_c;
      if (c_write) begin
         next_flag_c = carry_out;
      end
   end

   always @* begin
      next_flag_dc = flag_dc;
   end

   always @* begin
      next_flag_z = flag_z;
      if (z_write) begin
         next_flag_z = result_zero;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // next direction registers
   always @* begin
      next_port_a_direction = port_a_direction;
      next_port_b_direction = port_b_direction;
      next_port_c_direction = port_c_direction;
      if (is_dir_load) begin
         case (file_addr)
            {`CIES_DIR_HIGH, `CIES_DIR_PORT_A}: begin
               next_port_a_direction = w_reg;
            end
            {`CIES_DIR_HIGH, `CIES_DIR_PORT_B}: begin
               next_port_b_direction = w_reg;
            end
            {`CIES_DIR_HIGH, `CIES_DIR_PORT_C}: begin
               next_port_c_direction = w_reg;
            end
            default: begin
               next_port_a_direction = port_a_direction;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // next file write port; undefined ops write nothing
   always @* begin
      next_file_we    = 1'b0;
      next_file_waddr = file_waddr;
      next_file_wdata = file_wdata;
      if (take && to_file) begin
         next_file_we    = 1'b1;
         next_file_waddr = file_addr;
         next_file_wdata = result;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         pc <= `CIES_PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         w_reg <= `CIES_W_RESET;
      end else begin
         w_reg <= next_w_reg;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         flag_c <= `CIES_FLAG_RESET;
      end else begin
         flag_c <= next_flag_c;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         flag_dc <= `CIES_FLAG_RESET;
      end else begin
         flag_dc <= next_flag_dc;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         flag_z <= `CIES_FLAG_RESET;
      end else begin
         flag_z <= next_flag_z;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         port_a_direction <= `CIES_DIR_RESET;
      end else begin
         port_a_direction <= next_port_a_direction;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         port_b_direction <= `CIES_DIR_RESET;
      end else begin
         port_b_direction <= next_port_b_direction;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         port_c_direction <= `CIES_DIR_RESET;
      end else begin
         port_c_direction <= next_port_c_direction;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         file_we <= 1'b0;
      end else begin
         file_we <= next_file_we;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         file_waddr <= `CIES_FADDR_RESET;
      end else begin
         file_waddr <= next_file_waddr;
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         file_wdata <= `CIES_FDATA_RESET;
      end else begin
         file_wdata <= next_file_wdata;
      end
   end

endmodule // cies_core
`default_nettype wire

// file: tb/cies_core_properties.sv
// assertions for the execute subset core
// assumes a bind onto every cies_core instance
`timescale 1ns/1ps
`default_nettype none
`include "cies_consts.vh"
module cies_core_properties (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        exec_valid,
   input wire logic [3:0]  exec_op,
   input wire logic [6:0]  file_addr,
   input wire logic        dest_file,
   input wire logic [2:0]  bit_sel,
   input wire logic [7:0]  literal,
   input wire logic [7:0]  file_rdata,
   input wire logic [14:0] pc,
   input wire logic [7:0]  w_reg,
   input wire logic        flag_c,
   input wire logic        flag_dc,
   input wire logic        flag_z,
   input wire logic [7:0]  port_a_direction,
   input wire logic        file_we,
   input wire logic [6:0]  file_waddr,
   input wire logic [7:0]  file_wdata,
   input wire logic        busy
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   wire t = exec_valid && !busy;
   wire [3:0] o = exec_op;
   chk_jump_target: assert property (t && o == `CIES_OP_REL_JUMP |=> pc == $past(pc) + 15'h0001 + $past(w_reg))
      else $error("jump target wrong");
   chk_jump_discard: assert property (t && o == `CIES_OP_REL_JUMP |=> busy ##1 !busy)
      else $error("jump discard cycle wrong");
   chk_jump_flags: assert property (t && o == `CIES_OP_REL_JUMP |=> $stable({flag_c, flag_dc, flag_z}))
      else $error("jump changed flags");
   chk_bit_set: assert property (t && o == `CIES_OP_BIT_SET |=> file_we && file_wdata == ($past(file_rdata) | (8'h01 << $past(bit_sel))))
      else $error("bit set wrong");
   chk_left_carry: assert property (t && o == `CIES_OP_SHIFT_LEFT |=> flag_c == $past(file_rdata[7]))
      else $error("left shift carry wrong");
   chk_right_carry: assert property (t && o == `CIES_OP_SHIFT_RIGHT |=> flag_c == $past(file_rdata[0]))
      else $error("right shift carry wrong");
   chk_dest_file: assert property (t && dest_file && o == `CIES_OP_MOVE |=> file_we && file_waddr == $past(file_addr))
      else $error("file destination not written");
   chk_move_zero: assert property (t && o == `CIES_OP_MOVE |=> flag_z == ($past(file_rdata) == 8'h00))
      else $error("move zero flag wrong");
   chk_xor_imm: assert property (t && o == `CIES_OP_XOR_IMM |=> w_reg == ($past(w_reg) ^ $past(literal)))
      else $error("xor immediate wrong");
   chk_dir_load: assert property (t && o == `CIES_OP_DIR_LOAD && file_addr == 7'h05 |=> port_a_direction == $past(w_reg))
      else $error("direction load wrong");
   chk_swap_flags: assert property (t && o == `CIES_OP_SWAP |=> $stable({flag_c, flag_dc, flag_z}))
      else $error("swap changed flags");
   chk_xor_reg: assert property (t && o == `CIES_OP_XOR_REG && !dest_file |=> w_reg == ($past(w_reg) ^ $past(file_rdata)))
      else $error("xor register wrong");
   chk_left_zero: assert property (t && o == `CIES_OP_SHIFT_LEFT |=> flag_z == ($past(file_rdata[6:0]) == 7'h00))
      else $error("left shift zero flag wrong");
endmodule // cies_core_properties
bind cies_core cies_core_properties chk_i (.*);
`default_nettype wire

// file: tb/tb_top.sv
// bench for the execute subset core
// assumes file data is read combinationally by the core
`timescale 1ns/1ps
`default_nettype none
`include "cies_consts.vh"
module tb_top;
   logic        sys_clk = 0, sys_rst = 1, exec_valid = 0, dest_file = 0;
   logic [3:0]  exec_op = 0;
   logic [6:0]  file_addr = 0;
   logic [2:0]  bit_sel = 0, dc_in = 0;
   logic [7:0]  literal = 0, file_rdata = 0;
   wire  [14:0] pc;
   wire  [7:0]  w_reg, port_a_direction, port_b_direction, port_c_direction, file_wdata;
   wire  [6:0]  file_waddr;
   wire         flag_c, flag_dc, flag_z, file_we, busy;
   int          miscompares = 0, samples_checked = 0;
   logic [14:0] p;
   cies_core dut (
      .sys_clk          (sys_clk),
      .sys_rst          (sys_rst),
      .exec_valid       (exec_valid),
      .exec_op          (exec_op),
      .file_addr        (file_addr),
      .dest_file        (dest_file),
      .bit_sel          (bit_sel),
      .literal          (literal),
      .file_rdata       (file_rdata),
      .dc_in            (dc_in),
      .pc               (pc),
      .w_reg            (w_reg),
      .flag_c           (flag_c),
      .flag_dc          (flag_dc),
      .flag_z           (flag_z),
      .port_a_direction (port_a_direction),
      .port_b_direction (port_b_direction),
      .port_c_direction (port_c_direction),
      .file_we          (file_we),
      .file_waddr       (file_waddr),
      .file_wdata       (file_wdata),
      .busy             (busy)
   );
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic ex(input logic [3:0] op, input logic [6:0] a, input logic d, input logic [2:0] b,
                     input logic [7:0] l, input logic [7:0] f);
      exec_valid = 1;
      exec_op = op;
      file_addr = a;
      dest_file = d;
      bit_sel = b;
      literal = l;
      file_rdata = f;
      @(negedge sys_clk);
   endtask
   task automatic cmp(input string n, input logic [14:0] e, input logic [14:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_jump;
      ex(`CIES_OP_XOR_IMM, 0, 0, 0, 8'h05, 0);
      p = pc;
      ex(`CIES_OP_REL_JUMP, 0, 0, 0, 0, 0);
      cmp("pc", p + 15'h0006, pc);
      cmp("busy", 1, busy);
      ex(`CIES_OP_XOR_IMM, 0, 0, 0, 8'hFF, 0);
      cmp("w", 8'h05, w_reg);
      cmp("busy", 0, busy);
      cmp("z", 0, flag_z);
      cmp("dc", 0, flag_dc);
   endtask
   task automatic t_shift_move;
      ex(`CIES_OP_SHIFT_LEFT, 7'h10, 1, 0, 0, 8'h81);
      cmp("wdata", 8'h02, file_wdata);
      cmp("we", 1, file_we);
      cmp("c z", 2'b10, {flag_c, flag_z});
      ex(`CIES_OP_SHIFT_RIGHT, 7'h11, 0, 0, 0, 8'h01);
      cmp("w", 8'h00, w_reg);
      cmp("c z we", 3'b110, {flag_c, flag_z, file_we});
      ex(`CIES_OP_MOVE, 7'h20, 1, 0, 0, 8'h00);
      cmp("z waddr", {1'b1, 7'h20}, {flag_z, file_waddr});
      ex(`CIES_OP_SWAP, 7'h21, 0, 0, 0, 8'hA5);
      cmp("w", 8'h5A, w_reg);
      cmp("c z", 2'b11, {flag_c, flag_z});
      ex(`CIES_OP_XOR_REG, 7'h22, 0, 0, 0, 8'h0F);
      cmp("w", 8'h55, w_reg);
      cmp("c z", 2'b10, {flag_c, flag_z});
      ex(`CIES_OP_XOR_REG, 7'h24, 1, 0, 0, 8'h55);
      cmp("we wdata", {1'b1, 8'h00}, {file_we, file_wdata});
      cmp("w z", {8'h55, 1'b1}, {w_reg, flag_z});
   endtask
   task automatic t_bits_dirs;
      for (int b = 0; b < 8; b++) begin
         ex(`CIES_OP_BIT_SET, 7'h7F, 0, b, 0, 8'h00);
         cmp("set", {7'h7F, 8'h01 << b}, {file_waddr, file_wdata});
         cmp("z", 1, flag_z);
      end
      cmp("dirs", 3'b111, {&port_a_direction, &port_b_direction, &port_c_direction});
      for (int i = 5; i < 8; i++) begin
         ex(`CIES_OP_XOR_IMM, 0, 0, 0, w_reg ^ (8'h11 * i), 0);
         ex(`CIES_OP_DIR_LOAD, i, 0, 0, 0, 0);
      end
      ex(`CIES_OP_DIR_LOAD, 7'h04, 0, 0, 0, 0);
      cmp("dir a", 8'h55, port_a_direction);
      cmp("dir b", 8'h66, port_b_direction);
      cmp("dir c", 8'h77, port_c_direction);
      ex(4'hF, 7'h10, 1, 0, 0, 8'h12);
      cmp("we", 0, file_we);
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      sys_rst = 0;
      t_jump;
      t_shift_move;
      t_bits_dirs;
      end_of_test;
   end
   initial begin
      #100000;
      miscompares++;
      end_of_test;
   end
endmodule // tb_top
`default_nettype wire
